// file: shared/fail_out_pkg.sv
// constants, modes and pin functions for the fail output and gpio logic
// assumes a single 100 MHz clock taken from the internal oscillator
package fail_out_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    // blink line: 1.25 Hz held in hundredths of a hertz, 50 percent on
    localparam int unsigned BLINK_FREQ_CHZ = 125;
    localparam int unsigned BLINK_DUTY_PERMILLE = 500;
    localparam int unsigned BLINK_PERIOD_CYC = (CLK_HZ / BLINK_FREQ_CHZ) * 100;
    // pwm line: 100 Hz, duty in permille
    localparam int unsigned PWM_FREQ_HZ = 100;
    localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
    localparam int unsigned DUTY_20_PERMILLE = 200;
    localparam int unsigned DUTY_10_PERMILLE = 100;
    localparam int unsigned DUTY_5_PERMILLE = 50;
    localparam int unsigned DUTY_2P5_PERMILLE = 25;
    localparam logic [1:0] DUTY_SEL_20 = 2'h0;
    localparam logic [1:0] DUTY_SEL_10 = 2'h1;
    localparam logic [1:0] DUTY_SEL_5 = 2'h2;
    localparam logic [1:0] DUTY_SEL_RESET = DUTY_SEL_20;
    // failure thresholds
    localparam logic [2:0] UV_FAIL_COUNT = 3'h4;
    localparam logic [1:0] WATCHDOG_FAIL_FLAG_LIMIT = 2'h2;
    // hardware configurations 1 to 4
    localparam logic [1:0] HW_CFG1 = 2'h0;
    localparam logic [1:0] HW_CFG2 = 2'h1;
    localparam logic [1:0] HW_CFG3 = 2'h2;
    localparam logic [1:0] HW_CFG4 = 2'h3;

    typedef enum logic [2:0] {
        MODE_INIT = 3'h0,
        MODE_NORMAL = 3'h1,
        MODE_STOP = 3'h3,
        MODE_SLEEP = 3'h2,
        MODE_RESTART = 3'h6,
        MODE_FAILSAFE = 3'h7
    } mode_type;

    typedef enum logic [2:0] {
        PIN_FAIL = 3'h0,
        PIN_OFF = 3'h1,
        PIN_WAKE = 3'h3,
        PIN_LOW_SIDE = 3'h2,
        PIN_HIGH_SIDE = 3'h6
    } pin_fn_type;
endpackage : fail_out_pkg

// file: src/fail_pattern_gen.sv
// blink and pwm pattern generator for the fail lines
// assumes enable is a registered level; patterns restart in their on phase
`timescale 1ns/1ps
module fail_pattern_gen #(
    parameter int unsigned BLINK_CYC = fail_out_pkg::BLINK_PERIOD_CYC,
    parameter int unsigned PWM_CYC = fail_out_pkg::PWM_PERIOD_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control
    input wire logic enable,
    input wire logic [1:0] duty_sel,
    // patterns
    output logic blink_on,
    output logic pwm_on
);
    import fail_out_pkg::*;

    function automatic logic [31:0] part_of(input logic [31:0] period,
                                            input logic [31:0] permille);
        logic [63:0] prod;
        prod = 64'(period) * 64'(permille);
        return 32'(prod / 64'h3e8);
    endfunction : part_of

    logic [31:0] blink_cnt_reg;
    logic [31:0] pwm_cnt_reg;
    logic [31:0] pwm_permille;
    wire logic [31:0] blink_half = part_of(32'(BLINK_CYC), 32'(BLINK_DUTY_PERMILLE));
    wire logic [31:0] pwm_on_cyc = part_of(32'(PWM_CYC), pwm_permille);
    wire logic blink_wrap = (blink_cnt_reg == 32'(BLINK_CYC) - 32'h1);
    wire logic pwm_wrap = (pwm_cnt_reg == 32'(PWM_CYC) - 32'h1);

    assign pwm_permille = (duty_sel == DUTY_SEL_20) ? 32'(DUTY_20_PERMILLE) :
                          (duty_sel == DUTY_SEL_10) ? 32'(DUTY_10_PERMILLE) :
                          (duty_sel == DUTY_SEL_5) ? 32'(DUTY_5_PERMILLE) :
                          32'(DUTY_2P5_PERMILLE);

    // counters held at zero while idle so each activation starts in its on phase
    always_ff @(posedge mclk)
    begin
        if (rst || !enable || blink_wrap)
            blink_cnt_reg <= 32'h0;
        else
            blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (rst || !enable || pwm_wrap)
            pwm_cnt_reg <= 32'h0;
        else
            pwm_cnt_reg <= pwm_cnt_reg + 32'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            blink_on <= 1'b0;
            pwm_on <= 1'b0;
        end
        else
        begin
            blink_on <= enable && (blink_cnt_reg < blink_half);
            pwm_on <= enable && (pwm_cnt_reg < pwm_on_cyc);
        end
    end
endmodule : fail_pattern_gen

// file: src/fail_output_gpio.sv
// fail output logic with reassignable blink and pwm pins
// assumes mode, fault levels and spi strobes come synchronous from the core
`timescale 1ns/1ps
module fail_output_gpio #(
    parameter int unsigned BLINK_CYC = fail_out_pkg::BLINK_PERIOD_CYC,
    parameter int unsigned PWM_CYC = fail_out_pkg::PWM_PERIOD_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // device state
    input wire logic [2:0] device_mode,
    input wire logic [1:0] hw_config,
    // failure sources
    input wire logic watchdog_fail_flag_event,
    input wire logic wd_trigger_ok,
    input wire logic stop_wd_disabled,
    input wire logic thermal_shutdown_stage_two,
    input wire logic main_regulator_short,
    input wire logic main_regulator_ov,
    input wire logic main_regulator_uv_event,
    input wire logic uv_count_clear,
    // spi control
    input wire logic overvoltage_reset_enable,
    input wire logic fail_output_force_bit,
    input wire logic failure_flag_clear,
    input wire logic cfg_write,
    input wire logic [2:0] cfg_blink_fn,
    input wire logic [2:0] cfg_pwm_fn,
    input wire logic [1:0] cfg_switch_on,
    input wire logic [1:0] pwm_duty_select_field,
    input wire logic [1:0] wake_status_clear,
    // pins, bit 0 blink pin, bit 1 pwm pin
    input wire logic blink_fail_line_in,
    input wire logic pwm_fail_or_test_pin_in,
    output logic static_fail_line_out,
    output logic static_fail_line_oe,
    output logic blink_fail_line_out,
    output logic blink_fail_line_oe,
    output logic pwm_fail_or_test_pin_out,
    output logic pwm_fail_or_test_pin_oe,
    // status
    output logic failure_flag,
    output logic watchdog_fail_flag,
    output logic fail_safe_request,
    output logic [1:0] second_wake_status_register,
    output logic [1:0] wake_level_status_register
);
    import fail_out_pkg::*;

    // returns {oe, out} for a reassignable pin
    function automatic logic [1:0] pin_drive(input pin_fn_type fn,
                                             input logic sw_on,
                                             input logic pattern_on,
                                             input logic switch_run);
        logic [1:0] drv;
        drv = 2'h0;
        case (fn)
            PIN_FAIL: drv = {pattern_on, 1'b0};
            PIN_LOW_SIDE: drv = {sw_on && switch_run, 1'b0};
            PIN_HIGH_SIDE: drv = {sw_on && switch_run, 1'b1};
            default: drv = 2'h0;
        endcase
        return drv;
    endfunction : pin_drive

    logic [2:0] uv_cnt_reg;
    logic [2:0] uv_cnt_next;
    logic [1:0] wd_cnt_reg;
    logic [1:0] wd_cnt_next;
    logic failure_flag_next;
    logic watchdog_fail_flag_next;
    pin_fn_type blink_fn_reg;
    pin_fn_type pwm_fn_reg;
    logic [1:0] switch_on_reg;
    logic [1:0] duty_reg;
    logic [1:0] pin_prev_reg;
    logic [1:0] wake_next;
    logic blink_on;
    logic pwm_on;

    mode_type mode;
    assign mode = mode_type'(device_mode);

    wire logic [1:0] pin_in = {pwm_fail_or_test_pin_in, blink_fail_line_in};
    wire logic in_sleep = (mode == MODE_SLEEP);
    wire logic in_failsafe = (mode == MODE_FAILSAFE);
    wire logic in_restart = (mode == MODE_RESTART);
    wire logic switch_run = !in_restart && !in_failsafe && (mode != MODE_INIT);
    wire logic level_window = (mode == MODE_NORMAL) || (mode == MODE_STOP);

    // failure decoding
    wire logic ov_fault = main_regulator_ov && overvoltage_reset_enable;
    wire logic uv_fault = (uv_cnt_reg == UV_FAIL_COUNT);
    wire logic nonwd_fault = thermal_shutdown_stage_two || main_regulator_short ||
                             ov_fault || uv_fault;
    wire logic wd_limit_met = (hw_config == HW_CFG1) ? (wd_cnt_reg != 2'h0) :
                              (wd_cnt_reg >= WATCHDOG_FAIL_FLAG_LIMIT);
    wire logic wd_fault = watchdog_fail_flag && wd_limit_met;
    wire logic fault_now = nonwd_fault || wd_fault;
    wire logic wd_flag_clear = wd_trigger_ok || in_sleep ||
                               (in_failsafe && nonwd_fault) ||
                               ((mode == MODE_STOP) && stop_wd_disabled);
    wire logic wd_cnt_clear = in_sleep || (in_failsafe && nonwd_fault) ||
                              ((mode == MODE_STOP) && stop_wd_disabled);
    wire logic fo_active = failure_flag || fail_output_force_bit;
    wire logic cfg_take = cfg_write && (mode == MODE_NORMAL);

    // wake capability per pin
    wire logic wake_mode_ok = !in_failsafe && (mode != MODE_INIT);
    wire logic [1:0] wake_cap = {(pwm_fn_reg == PIN_WAKE) && wake_mode_ok,
                                 (blink_fn_reg == PIN_WAKE) && wake_mode_ok};
    wire logic [1:0] wake_evt = wake_cap & (pin_in ^ pin_prev_reg);
    wire logic [1:0] level_show = {(pwm_fn_reg != PIN_FAIL) && (pwm_fn_reg != PIN_OFF),
                                   (blink_fn_reg != PIN_FAIL) && (blink_fn_reg != PIN_OFF)};

    wire logic [1:0] blink_drv = pin_drive(blink_fn_reg, switch_on_reg[0], blink_on,
                                           switch_run);
    wire logic [1:0] pwm_drv = pin_drive(pwm_fn_reg, switch_on_reg[1], pwm_on,
                                         switch_run);

    fail_pattern_gen #(
        .BLINK_CYC(BLINK_CYC),
        .PWM_CYC(PWM_CYC)
    ) u_pattern (
        .mclk(mclk),
        .rst(rst),
        .enable(fo_active),
        .duty_sel(duty_reg),
        .blink_on(blink_on),
        .pwm_on(pwm_on)
    );

    // consecutive undervoltage counter, saturating at the fail count
    assign uv_cnt_next = uv_count_clear ? 3'h0 :
                         (main_regulator_uv_event && !uv_fault) ? uv_cnt_reg + 3'h1 :
                         uv_cnt_reg;
    assign wd_cnt_next = (watchdog_fail_flag_event && (wd_cnt_reg != WATCHDOG_FAIL_FLAG_LIMIT)) ?
                         wd_cnt_reg + 2'h1 :
                         wd_cnt_clear ? 2'h0 : wd_cnt_reg;
    // hardware sets win over software and mode clears
    assign watchdog_fail_flag_next = watchdog_fail_flag_event ? 1'b1 :
                                     wd_flag_clear ? 1'b0 : watchdog_fail_flag;
    assign failure_flag_next = fault_now ? 1'b1 :
                               failure_flag_clear ? 1'b0 : failure_flag;
    assign wake_next = wake_evt | (second_wake_status_register & ~wake_status_clear);

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            uv_cnt_reg <= 3'h0;
            wd_cnt_reg <= 2'h0;
            watchdog_fail_flag <= 1'b0;
            failure_flag <= 1'b0;
        end
        else
        begin
            uv_cnt_reg <= uv_cnt_next;
            wd_cnt_reg <= wd_cnt_next;
            watchdog_fail_flag <= watchdog_fail_flag_next;
            failure_flag <= failure_flag_next;
        end
    end

    // fail-safe only for failures other than the watchdog, except config 1
    always_ff @(posedge mclk)
    begin
        if (rst)
            fail_safe_request <= 1'b0;
        else
            fail_safe_request <= nonwd_fault || (wd_fault && hw_config == HW_CFG1);
    end

    // pin configuration, never touched by failures or mode changes
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            blink_fn_reg <= PIN_FAIL;
            pwm_fn_reg <= PIN_FAIL;
            switch_on_reg <= 2'h0;
            duty_reg <= DUTY_SEL_RESET;
        end
        else if (cfg_take)
        begin
            blink_fn_reg <= pin_fn_type'(cfg_blink_fn);
            pwm_fn_reg <= pin_fn_type'(cfg_pwm_fn);
            switch_on_reg <= cfg_switch_on;
            duty_reg <= pwm_duty_select_field;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pin_prev_reg <= 2'h3;
            second_wake_status_register <= 2'h0;
            wake_level_status_register <= 2'h0;
        end
        else
        begin
            pin_prev_reg <= pin_in;
            second_wake_status_register <= wake_next;
            if (level_window)
                wake_level_status_register <= pin_in & level_show;
        end
    end

    // pin drivers: open-drain lines pull low while enabled
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            static_fail_line_out <= 1'b0;
            static_fail_line_oe <= 1'b0;
            blink_fail_line_out <= 1'b0;
            blink_fail_line_oe <= 1'b0;
            pwm_fail_or_test_pin_out <= 1'b0;
            pwm_fail_or_test_pin_oe <= 1'b0;
        end
        else
        begin
            static_fail_line_out <= 1'b0;
            static_fail_line_oe <= fo_active;
            blink_fail_line_oe <= blink_drv[1];
            blink_fail_line_out <= blink_drv[0];
            pwm_fail_or_test_pin_oe <= pwm_drv[1];
            pwm_fail_or_test_pin_out <= pwm_drv[0];
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    property p_static_on;
        fo_active |=> static_fail_line_oe && !static_fail_line_out;
    endproperty
    a_static_on: assert property (p_static_on)
        else $error("static fail line not driven low while active");

    property p_static_off;
        !fo_active |=> !static_fail_line_oe;
    endproperty
    a_static_off: assert property (p_static_off)
        else $error("static fail line driven while inactive");

    property p_fault_sets_flag;
        fault_now |=> failure_flag;
    endproperty
    a_fault_sets_flag: assert property (p_fault_sets_flag)
        else $error("failure flag not set by fault");

    property p_thermal;
        thermal_shutdown_stage_two ##1 1'b1 |=> static_fail_line_oe;
    endproperty
    a_thermal: assert property (p_thermal)
        else $error("thermal shutdown did not activate fail lines");

    property p_ov_gated;
        (main_regulator_ov && !overvoltage_reset_enable && !nonwd_fault && !wd_fault
         && !failure_flag) |=> !failure_flag;
    endproperty
    a_ov_gated: assert property (p_ov_gated)
        else $error("overvoltage activated without reset enable");

    property p_uv_fourth;
        (uv_cnt_reg == 3'h3 && main_regulator_uv_event && !uv_count_clear)
            |=> ##1 failure_flag;
    endproperty
    a_uv_fourth: assert property (p_uv_fourth)
        else $error("fourth undervoltage did not set failure");

    property p_flag_holds;
        failure_flag && !failure_flag_clear |=> failure_flag;
    endproperty
    a_flag_holds: assert property (p_flag_holds)
        else $error("failure flag dropped without clear");

    property p_cfg2_first;
        (hw_config == HW_CFG2 && wd_cnt_reg < WATCHDOG_FAIL_FLAG_LIMIT) |-> !wd_fault;
    endproperty
    a_cfg2_first: assert property (p_cfg2_first)
        else $error("first watchdog failure counted in config 2");

    property p_sleep_clears_wd;
        (in_sleep && !watchdog_fail_flag_event) |=> !watchdog_fail_flag;
    endproperty
    a_sleep_clears_wd: assert property (p_sleep_clears_wd)
        else $error("watchdog flag not cleared in sleep");

    property p_cfg_frozen;
        (mode != MODE_NORMAL) |=> $stable(blink_fn_reg) && $stable(pwm_fn_reg)
            && $stable(duty_reg);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen)
        else $error("pin configuration changed outside normal mode");

    property p_switch_off_restart;
        (in_restart && pwm_fn_reg != PIN_FAIL) |=> !pwm_fail_or_test_pin_oe;
    endproperty
    a_switch_off_restart: assert property (p_switch_off_restart)
        else $error("reassigned pin driven in restart");

    property p_pattern_start;
        $rose(fo_active) && !cfg_take && blink_fn_reg == PIN_FAIL |=> ##1 blink_fail_line_oe;
    endproperty
    a_pattern_start: assert property (p_pattern_start)
        else $error("blink line did not start in its on phase");

    property p_nonwd_failsafe;
        nonwd_fault |=> fail_safe_request;
    endproperty
    a_nonwd_failsafe: assert property (p_nonwd_failsafe)
        else $error("non-watchdog failure did not request fail-safe");

    property p_wake_off_failsafe;
        in_failsafe && second_wake_status_register == 2'h0 |=> second_wake_status_register == 2'h0;
    endproperty
    a_wake_off_failsafe: assert property (p_wake_off_failsafe)
        else $error("wake event recorded in fail-safe");

    c_failure_cycle: cover property (failure_flag ##[1:20] !failure_flag);
    c_pwm_pulse: cover property ($rose(pwm_fail_or_test_pin_oe) ##[1:1000]
                                 $fell(pwm_fail_or_test_pin_oe));
    c_wake_event: cover property ($rose(second_wake_status_register[0]));
    c_forced: cover property (fail_output_force_bit && !failure_flag
                              ##1 static_fail_line_oe);
endmodule : fail_output_gpio

// file: verification/fail_lamp_model.sv
// far side of the fail lines: pulled-up lamp and receiver inputs
// assumes the bench sets the external level of the two reassignable pins
`timescale 1ns/1ps
module fail_lamp_model (
    // device drivers
    input wire logic static_out,
    input wire logic static_oe,
    input wire logic blink_out,
    input wire logic blink_oe,
    input wire logic pwm_out,
    input wire logic pwm_oe,
    // external source on the reassignable pins, 1 = pull-up only
    input wire logic blink_ext,
    input wire logic pwm_ext,
    // resolved wire levels
    output logic static_level,
    output logic blink_level,
    output logic pwm_level
);
    // an undriven open-drain line floats to its pull-up
    assign static_level = static_oe ? static_out : 1'b1;
    assign blink_level = blink_oe ? blink_out : blink_ext;
    assign pwm_level = pwm_oe ? pwm_out : pwm_ext;
endmodule : fail_lamp_model

// file: verification/tb.sv
// self-checking bench for the fail output and gpio logic
// assumes short pattern periods: blink 40 cycles, pwm 1000 cycles
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
    import fail_out_pkg::*;
    localparam int unsigned BC = 40;
    localparam int unsigned PC = 1000;
    logic mclk = 1'b0, rst = 1'b1;
    logic [2:0] device_mode = MODE_NORMAL;
    logic [1:0] hw_config = HW_CFG1;
    logic watchdog_fail_flag_event = 0, wd_trigger_ok = 0, stop_wd_disabled = 0;
    logic thermal = 0, vshort = 0, vov = 0, uv_ev = 0, uv_clr = 0;
    logic ov_en = 0, force_on = 0, fclr = 0, cfg_write = 0;
    logic [2:0] cfg_blink_fn = PIN_FAIL, cfg_pwm_fn = PIN_FAIL;
    logic [1:0] cfg_switch_on = 2'h0, duty = DUTY_SEL_RESET, wclr = 2'h0;
    logic blink_ext = 1'b1, pwm_ext = 1'b1;
    logic s_out, s_oe, b_out, b_oe, p_out, p_oe, s_lvl, b_lvl, p_lvl;
    logic failure_flag, wd_flag, fs_req;
    logic [1:0] wake_stat, wake_lvl;
    int error_cnt = 0, samples_checked = 0;

    always #5 mclk = ~mclk;

    fail_output_gpio #(.BLINK_CYC(BC), .PWM_CYC(PC)) dut (
        .mclk(mclk), .rst(rst), .device_mode(device_mode), .hw_config(hw_config),
        .watchdog_fail_flag_event(watchdog_fail_flag_event), .wd_trigger_ok(wd_trigger_ok),
        .stop_wd_disabled(stop_wd_disabled), .thermal_shutdown_stage_two(thermal),
        .main_regulator_short(vshort), .main_regulator_ov(vov),
        .main_regulator_uv_event(uv_ev), .uv_count_clear(uv_clr),
        .overvoltage_reset_enable(ov_en), .fail_output_force_bit(force_on),
        .failure_flag_clear(fclr), .cfg_write(cfg_write), .cfg_blink_fn(cfg_blink_fn),
        .cfg_pwm_fn(cfg_pwm_fn), .cfg_switch_on(cfg_switch_on),
        .pwm_duty_select_field(duty), .wake_status_clear(wclr),
        .blink_fail_line_in(b_lvl), .pwm_fail_or_test_pin_in(p_lvl),
        .static_fail_line_out(s_out), .static_fail_line_oe(s_oe),
        .blink_fail_line_out(b_out), .blink_fail_line_oe(b_oe),
        .pwm_fail_or_test_pin_out(p_out), .pwm_fail_or_test_pin_oe(p_oe),
        .failure_flag(failure_flag), .watchdog_fail_flag(wd_flag),
        .fail_safe_request(fs_req), .second_wake_status_register(wake_stat),
        .wake_level_status_register(wake_lvl)
    );

    fail_lamp_model lamps (
        .static_out(s_out), .static_oe(s_oe), .blink_out(b_out), .blink_oe(b_oe),
        .pwm_out(p_out), .pwm_oe(p_oe), .blink_ext(blink_ext), .pwm_ext(pwm_ext),
        .static_level(s_lvl), .blink_level(b_lvl), .pwm_level(p_lvl)
    );

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    // one-cycle strobe: 0 clear, 1 uv, 2 watchdog_fail_flag_event, 3 trigger ok, 4 cfg, 5 uv clear
    task automatic pulse(input int k);
        case (k)
            0: fclr = 1;
            1: uv_ev = 1;
            2: watchdog_fail_flag_event = 1;
            3: wd_trigger_ok = 1;
            4: cfg_write = 1;
            default: uv_clr = 1;
        endcase
        cyc(1);
        {fclr, uv_ev, watchdog_fail_flag_event, wd_trigger_ok, cfg_write, uv_clr} = '0;
    endtask : pulse

    task automatic count_low(input int n, output int bl, output int pl);
        bl = 0;
        pl = 0;
        repeat (n)
        begin
            if (b_lvl === 1'b0) bl++;
            if (p_lvl === 1'b0) pl++;
            cyc(1);
        end
    endtask : count_low

    task automatic t_reset;
        `CHK({s_oe, b_oe, p_oe, failure_flag, wd_flag, fs_req}, 6'h00)
        `CHK({s_lvl, b_lvl, p_lvl}, 3'h7)
    endtask : t_reset

    // thermal, short, overvoltage enabled, overvoltage disabled
    task automatic t_sources;
        logic e;
        for (int i = 0; i < 4; i++)
        begin
            e = (i != 3);
            ov_en = (i == 2);
            {thermal, vshort, vov} = {i == 0, i == 1, i >= 2};
            cyc(1);
            `CHK(failure_flag, e)
            `CHK(fs_req, e)
            cyc(2);
            `CHK({s_lvl, b_lvl, p_lvl}, {3{~e}})
            if (i == 0)
            begin
                device_mode = MODE_RESTART;
                cyc(3);
                device_mode = MODE_NORMAL;
                cyc(2);
                `CHK(s_lvl, 1'b0)
            end
            pulse(0);
            `CHK(failure_flag, e)
            {thermal, vshort, vov} = 3'h0;
            cyc(2);
            `CHK(s_oe, e)
            pulse(0);
            cyc(2);
            `CHK({failure_flag, s_oe, b_oe, p_oe}, 4'h0)
        end
        ov_en = 0;
    endtask : t_sources

    task automatic t_patterns;
        int bl, pl;
        int exp_pl[4] = '{200, 100, 50, 25};
        for (int d = 0; d < 4; d++)
        begin
            duty = d[1:0];
            pulse(4);
            force_on = 1;
            cyc(2);
            `CHK({s_lvl, b_lvl, p_lvl}, 3'h0)
            count_low(PC, bl, pl);
            `CHK(pl, exp_pl[d])
            count_low(BC, bl, pl);
            `CHK(bl, BC / 2)
            `CHK(s_lvl, 1'b0)
            force_on = 0;
            cyc(3);
            `CHK({s_oe, b_oe, p_oe}, 3'h0)
        end
    endtask : t_patterns

    task automatic t_uv;
        repeat (3) pulse(1);
        pulse(5);
        pulse(1);
        cyc(2);
        `CHK(failure_flag, 1'b0)
        repeat (2) pulse(1);
        cyc(2);
        `CHK(failure_flag, 1'b0)
        pulse(1);
        cyc(1);
        `CHK(failure_flag, 1'b1)
        pulse(5);
        pulse(0);
        cyc(1);
        `CHK(failure_flag, 1'b0)
    endtask : t_uv

    task automatic t_watchdog;
        logic c1;
        for (int c = 0; c < 4; c++)
        begin
            hw_config = c[1:0];
            c1 = (c[1:0] == HW_CFG1);
            cyc(2);
            pulse(2);
            cyc(1);
            `CHK(failure_flag, c1)
            cyc(2);
            pulse(2);
            cyc(1);
            `CHK(failure_flag, 1'b1)
            `CHK(wd_flag, 1'b1)
            `CHK(fs_req, c1)
            pulse(3);
            `CHK(wd_flag, 1'b0)
            pulse(2);
            device_mode = (c < 2) ? MODE_SLEEP : MODE_STOP;
            stop_wd_disabled = 1;
            cyc(2);
            `CHK(wd_flag, 1'b0)
            stop_wd_disabled = 0;
            device_mode = MODE_NORMAL;
            pulse(3);
            cyc(1);
            pulse(0);
            `CHK(failure_flag, 1'b0)
            cyc(3);
        end
        hw_config = HW_CFG1;
    endtask : t_watchdog

    task automatic t_gpio;
        cfg_blink_fn = PIN_WAKE;
        cfg_pwm_fn = PIN_LOW_SIDE;
        cfg_switch_on = 2'h2;
        pulse(4);
        cyc(2);
        `CHK(p_oe, 1'b1)
        `CHK(wake_lvl, {p_lvl, 1'b1})
        blink_ext = 0;
        cyc(3);
        `CHK(wake_stat[0], 1'b1)
        `CHK(wake_lvl[0], 1'b0)
        wclr = 2'h3;
        cyc(1);
        wclr = 2'h0;
        cyc(1);
        `CHK(wake_stat, 2'h0)
        device_mode = MODE_STOP;
        cfg_pwm_fn = PIN_OFF;
        pulse(4);
        cyc(2);
        `CHK(p_oe, 1'b1)
        `CHK(wake_lvl[1], p_lvl)
        device_mode = MODE_RESTART;
        cyc(2);
        `CHK(p_oe, 1'b0)
        blink_ext = 1;
        cyc(3);
        `CHK(wake_stat[0], 1'b1)
        wclr = 2'h3;
        cyc(1);
        wclr = 2'h0;
        device_mode = MODE_FAILSAFE;
        cyc(2);
        blink_ext = 0;
        cyc(3);
        `CHK(wake_stat[0], 1'b0)
        `CHK(p_oe, 1'b0)
        device_mode = MODE_NORMAL;
        cyc(3);
        `CHK(p_oe, 1'b1)
        cfg_pwm_fn = PIN_HIGH_SIDE;
        pulse(4);
        cyc(2);
        `CHK({p_oe, p_out}, 2'h3)
        `CHK(wake_lvl[1], 1'b1)
    endtask : t_gpio

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    initial
    begin
        #(400_000);
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        cyc(12);
        rst = 0;
        cyc(1);
        t_reset();
        t_sources();
        t_patterns();
        t_uv();
        t_watchdog();
        t_gpio();
        wrap_up();
    end
endmodule : tb
